// [logic/exposure_readout_timing_control.sv]
// exposure and readout timing controller, global-shutter sensor
// assumes one 100 MHz clock, settings arrive as decoded commands
//
// Functional notes
// - pixel-rate code 80 gives 40 MHz, code 160 gives 80 MHz
// - current pixel-rate code is always readable
// - modes 4 and 9: trigger rise starts integration, fall starts readout
// - integration of one frame may overlap readout of the last
// - readout lasts a fixed time set by configuration, 10 ms at code 160, 20 ms at code 80
// - overlapped frame rate reaches 100 fps as waiting shrinks
// - mode 2 times frames internally, exposure at least 40 us
// - modes 4 and 9 expose for trigger high time, mins 40/10 us
// - exposure mode takes only 2, 4, 6, 9, 10; resets to 2
// - exposure time accepted only in modes 2, 6 and 10
// - out-of-range exposure is clipped to the nearest limit
// - exposure overlapping readout drops its fraction, warns
// - exposure given in microseconds with fraction, 40 (10 in mode 10) to 4000000
// - long exposure lowers frame rate and warns
// - mode 6 trigger fall starts programmed-length exposure
// - triggered exposure begins 100 us after the trigger event
// - mode 4 fall during readout holds exposure until that readout ends
// - new mode 2 frame period shortens exposure to fit
`timescale 1ns/100ps

`include "exposure_timing_consts.svh"

module exposure_readout_timing_control #(
  parameter int READOUT_US    = `READOUT_US,
  parameter int TRIG_DELAY_US = `TRIG_DELAY_US
) (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RST_N,
  input  wire logic                        EXT_FRAME_TRIGGER,
  input  wire logic                        OVERLAP_EN,
  input  wire logic                        CMD_STB,
  input  wire exposure_timing_pkg::cmd_sel_t CMD_SEL,
  input  wire logic [31:0]                 CMD_DATA,
  output wire logic                        INTEG_START,
  output wire logic                        READ_START,
  output wire logic                        INTEGRATING,
  output wire logic                        READING,
  output wire logic                        WARN_EXP,
  output wire logic                        WARN_RATE,
  output wire logic                        CMD_REJECT,
  output wire logic [3:0]                  MODE_RD,
  output wire logic [25:0]                 EXP_RD,
  output wire logic [23:0]                 PERIOD_RD,
  output wire logic [7:0]                  RATE_RD
);

  localparam int TICK_CYC = `NS_PER_US / `CLK_PERIOD_NS;

  if (TICK_CYC < 1 || TICK_CYC > 128) begin : g_chk_tick
    $error("clock rate does not fit the microsecond divider");
  end
  if (READOUT_US < 1 || 2 * READOUT_US > 65535) begin : g_chk_rd
    $error("readout time does not fit the readout counter");
  end
  if (TRIG_DELAY_US < 1 || TRIG_DELAY_US > 8388607) begin : g_chk_dly
    $error("trigger delay does not fit the delay counter");
  end

  localparam logic [6:0]  TICK_LAST = 7'(TICK_CYC - 1);
  localparam logic [15:0] RD_FAST   = 16'(READOUT_US);
  localparam logic [15:0] RD_SLOW   = 16'(2 * READOUT_US);
  localparam logic [22:0] DLY_LAST  = 23'(TRIG_DELAY_US - 1);

  exposure_timing_pkg::st_t st_r;
  exposure_timing_pkg::st_t st_nxt;

  always_comb begin
    logic        rise;
    logic        fall;
    logic        smart;
    logic        done;
    logic [21:0] ei;
    logic [3:0]  ef;
    logic [21:0] emin;
    logic [23:0] pv;
    logic [15:0] rlen;
    logic [15:0] rlen_p;
    st_nxt = st_r;
    st_nxt.integ_start = 1'b0;
    st_nxt.read_start  = 1'b0;
    st_nxt.warn_exp    = 1'b0;
    st_nxt.warn_rate   = 1'b0;
    st_nxt.cmd_reject  = 1'b0;
    rise   = 1'b0;
    fall   = 1'b0;
    smart  = 1'b0;
    done   = 1'b0;
    rlen   = '0;
    rlen_p = '0;
    ei   = '0;
    ef   = '0;
    emin = '0;
    pv   = '0;

    // trigger pin: level changes once second and third stage agree
    st_nxt.trig_s = {st_r.trig_s[1:0], EXT_FRAME_TRIGGER};
    if (st_r.trig_s[1] == st_r.trig_s[2]) begin
      st_nxt.trig_lvl = st_r.trig_s[2];
    end
    rise = st_nxt.trig_lvl & ~st_r.trig_lvl;
    fall = ~st_nxt.trig_lvl & st_r.trig_lvl;

    // one pulse per microsecond
    st_nxt.tick     = (st_r.tick_cnt == TICK_LAST);
    st_nxt.tick_cnt = st_nxt.tick ? 7'h0 : st_r.tick_cnt + 7'h1;

    smart = (st_r.mode_a == `MODE_SMART) ||
            (st_r.mode_a == `MODE_SMART_SEQ);
    rlen = (st_r.rate_a == `RATE_CODE_FAST) ? RD_FAST : RD_SLOW;
    rlen_p = (st_r.rate_p == `RATE_CODE_FAST) ? RD_FAST : RD_SLOW;

    // readout countdown runs beside any exposure
    if (st_r.reading && st_r.tick) begin
      st_nxt.rd_cnt = st_r.rd_cnt - 16'h1;
      if (st_r.rd_cnt == 16'h1) begin
        st_nxt.reading = 1'b0;
      end
    end

    case (st_r.state)
      exposure_timing_pkg::EXP_IDLE: begin
        // frame boundary: adopt settings held pending
        st_nxt.mode_a = st_r.mode_p;
        st_nxt.exp_a  = st_r.exp_p[25:4];
        st_nxt.per_a  = st_r.per_p;
        st_nxt.rate_a = st_r.rate_p;
        st_nxt.ovl_a  = OVERLAP_EN;
        st_nxt.cnt    = '0;
        case (st_r.mode_a)
          `MODE_INT: begin
            if (st_r.frame_due && (st_r.ovl_a || !st_r.reading)) begin
              st_nxt.frame_due   = 1'b0;
              st_nxt.state       = exposure_timing_pkg::EXP_ACTIVE;
              st_nxt.integ_start = 1'b1;
              st_nxt.integrating = 1'b1;
            end
          end
          `MODE_SMART: begin
            if (rise) begin
              st_nxt.state = exposure_timing_pkg::EXP_DELAY;
            end
          end
          `MODE_SMART_SEQ: begin
            if (rise && !st_r.reading) begin
              st_nxt.state = exposure_timing_pkg::EXP_DELAY;
            end
          end
          `MODE_FIXED: begin
            if (fall) begin
              st_nxt.state = exposure_timing_pkg::EXP_DELAY;
            end
          end
          `MODE_FIXED_SEQ: begin
            if (fall && !st_r.reading) begin
              st_nxt.state = exposure_timing_pkg::EXP_DELAY;
            end
          end
          default: begin
            st_nxt.state = exposure_timing_pkg::EXP_IDLE;
          end
        endcase
      end
      exposure_timing_pkg::EXP_DELAY: begin
        if (st_r.tick) begin
          if (st_r.cnt == DLY_LAST) begin
            st_nxt.cnt         = '0;
            st_nxt.state       = exposure_timing_pkg::EXP_ACTIVE;
            st_nxt.integ_start = 1'b1;
            st_nxt.integrating = 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt + 23'h1;
          end
        end
      end
      exposure_timing_pkg::EXP_ACTIVE: begin
        if (st_r.tick && st_r.cnt != '1) begin
          st_nxt.cnt = st_r.cnt + 23'h1;
        end
        if (smart) begin
          emin = (st_r.mode_a == `MODE_SMART_SEQ) ?
                 `EXP_MIN_SHORT_US : `EXP_MIN_US;
          done = !st_r.trig_lvl && st_r.cnt >= {1'b0, emin};
        end else begin
          done = st_r.cnt >= {1'b0, st_r.exp_a};
        end
        // exposure stretches while the last frame still reads out
        if (done && !st_r.reading) begin
          st_nxt.state       = exposure_timing_pkg::EXP_IDLE;
          st_nxt.integrating = 1'b0;
          st_nxt.read_start  = 1'b1;
          st_nxt.reading     = 1'b1;
          st_nxt.rd_cnt      = rlen;
        end
      end
      default: begin
        st_nxt.state = exposure_timing_pkg::EXP_IDLE;
      end
    endcase

    // internal frame clock; a new frame due wins over its clear
    if (st_r.mode_a != `MODE_INT) begin
      st_nxt.frame_cnt = '0;
      st_nxt.frame_due = 1'b0;
    end else if (st_r.tick) begin
      if (st_r.frame_cnt >= st_r.per_a - 24'h1) begin
        st_nxt.frame_cnt = '0;
        st_nxt.frame_due = 1'b1;
      end else begin
        st_nxt.frame_cnt = st_r.frame_cnt + 24'h1;
      end
    end

    // settings commands
    if (CMD_STB) begin
      case (CMD_SEL)
        exposure_timing_pkg::CMD_MODE: begin
          if (CMD_DATA == {28'h0, `MODE_INT} ||
              CMD_DATA == {28'h0, `MODE_SMART} ||
              CMD_DATA == {28'h0, `MODE_FIXED} ||
              CMD_DATA == {28'h0, `MODE_SMART_SEQ} ||
              CMD_DATA == {28'h0, `MODE_FIXED_SEQ}) begin
            st_nxt.mode_p = CMD_DATA[3:0];
          end else begin
            st_nxt.cmd_reject = 1'b1;
          end
        end
        exposure_timing_pkg::CMD_EXPOSURE: begin
          if (st_r.mode_p == `MODE_INT || st_r.mode_p == `MODE_FIXED ||
              st_r.mode_p == `MODE_FIXED_SEQ) begin
            emin = (st_r.mode_p == `MODE_FIXED_SEQ) ?
                   `EXP_MIN_SHORT_US : `EXP_MIN_US;
            if (|CMD_DATA[31:26] || CMD_DATA[25:4] > `EXP_MAX_US) begin
              {ei, ef} = {`EXP_MAX_US, `EXP_FRAC_ZERO};
            end else if (CMD_DATA[25:4] < emin) begin
              {ei, ef} = {emin, `EXP_FRAC_ZERO};
            end else begin
              {ei, ef} = CMD_DATA[25:0];
            end
            if (st_r.mode_p == `MODE_INT) begin
              if (ef != `EXP_FRAC_ZERO &&
                  {2'b0, ei} + {8'h0, rlen_p} > st_r.per_p) begin
                ef              = `EXP_FRAC_ZERO;
                st_nxt.warn_exp = 1'b1;
              end
              if ({2'b0, ei} > st_r.per_p) begin
                st_nxt.per_p     = {2'b0, ei};
                st_nxt.warn_rate = 1'b1;
              end
            end
            st_nxt.exp_p = {ei, ef};
          end else begin
            st_nxt.cmd_reject = 1'b1;
          end
        end
        exposure_timing_pkg::CMD_PERIOD: begin
          if (st_r.mode_p == `MODE_INT) begin
            if (|CMD_DATA[31:24] || CMD_DATA[23:0] > `PERIOD_MAX_US) begin
              pv = `PERIOD_MAX_US;
            end else if (CMD_DATA[23:0] < {8'h0, rlen_p}) begin
              pv = {8'h0, rlen_p};
            end else begin
              pv = CMD_DATA[23:0];
            end
            st_nxt.per_p = pv;
            if ({2'b0, st_r.exp_p[25:4]} > pv) begin
              st_nxt.exp_p    = {pv[21:0], `EXP_FRAC_ZERO};
              st_nxt.warn_exp = 1'b1;
            end
          end else begin
            st_nxt.cmd_reject = 1'b1;
          end
        end
        default: begin
          if (CMD_DATA == {24'h0, `RATE_CODE_SLOW} ||
              CMD_DATA == {24'h0, `RATE_CODE_FAST}) begin
            st_nxt.rate_p = CMD_DATA[7:0];
          end else begin
            st_nxt.cmd_reject = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_r        <= '0;
      st_r.mode_p <= `MODE_INT;
      st_r.mode_a <= `MODE_INT;
      st_r.exp_p  <= {`EXP_RESET_US, `EXP_FRAC_ZERO};
      st_r.exp_a  <= `EXP_RESET_US;
      st_r.per_p  <= `PERIOD_RESET_US;
      st_r.per_a  <= `PERIOD_RESET_US;
      st_r.rate_p <= `RATE_CODE_FAST;
      st_r.rate_a <= `RATE_CODE_FAST;
      st_r.ovl_a  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign INTEG_START = st_r.integ_start;
  assign READ_START  = st_r.read_start;
  assign INTEGRATING = st_r.integrating;
  assign READING     = st_r.reading;
  assign WARN_EXP    = st_r.warn_exp;
  assign WARN_RATE   = st_r.warn_rate;
  assign CMD_REJECT  = st_r.cmd_reject;
  assign MODE_RD     = st_r.mode_p;
  assign EXP_RD      = st_r.exp_p;
  assign PERIOD_RD   = st_r.per_p;
  assign RATE_RD     = st_r.rate_p;

endmodule

// [logic/exposure_timing_consts.svh]
// constants for the exposure and readout timing controller
// assumes a 100 MHz core clock; times kept in microseconds
`ifndef EXPOSURE_TIMING_CONSTS_SVH
`define EXPOSURE_TIMING_CONSTS_SVH

`define CLK_PERIOD_NS     32'ha
`define NS_PER_US         32'h3e8
`define TRIG_DELAY_US     32'h64
`define READOUT_US        32'h2710

`define EXP_MIN_US        22'h28
`define EXP_MIN_SHORT_US  22'ha
`define EXP_MAX_US        22'h3d0900
`define EXP_RESET_US      22'h2328
`define EXP_FRAC_ZERO     4'h0

`define PERIOD_RESET_US   24'h2710
`define PERIOD_MAX_US     24'h989680

`define MODE_INT          4'h2
`define MODE_SMART        4'h4
`define MODE_FIXED        4'h6
`define MODE_SMART_SEQ    4'h9
`define MODE_FIXED_SEQ    4'ha

`define RATE_CODE_SLOW    8'h50
`define RATE_CODE_FAST    8'ha0

`endif

// [logic/exposure_timing_pkg.sv]
// types for the exposure and readout timing controller
// assumes the constants header is compiled alongside
package exposure_timing_pkg;

  typedef enum logic [1:0] {
    CMD_MODE,
    CMD_EXPOSURE,
    CMD_PERIOD,
    CMD_RATE
  } cmd_sel_t;

  typedef enum logic [1:0] {
    EXP_IDLE,
    EXP_DELAY,
    EXP_ACTIVE
  } exp_state_t;

  typedef struct packed {
    logic [2:0]  trig_s;
    logic        trig_lvl;
    logic [6:0]  tick_cnt;
    logic        tick;
    exp_state_t  state;
    logic [22:0] cnt;
    logic [23:0] frame_cnt;
    logic        frame_due;
    logic [15:0] rd_cnt;
    logic [3:0]  mode_p;
    logic [3:0]  mode_a;
    logic [25:0] exp_p;
    logic [21:0] exp_a;
    logic [23:0] per_p;
    logic [23:0] per_a;
    logic [7:0]  rate_p;
    logic [7:0]  rate_a;
    logic        ovl_a;
    logic        integ_start;
    logic        read_start;
    logic        integrating;
    logic        reading;
    logic        warn_exp;
    logic        warn_rate;
    logic        cmd_reject;
  } st_t;

endpackage

// [dv/exposure_timing_checker.sv]
// assertions on the ports of the exposure timing controller
// assumes a bind onto the top module, one clock domain
`timescale 1ns/100ps
module exposure_timing_checker #(
  parameter int READOUT_US = 10000
) (
  input wire logic                          CORE_CLK,
  input wire logic                          RST_N,
  input wire logic                          CMD_STB,
  input wire exposure_timing_pkg::cmd_sel_t CMD_SEL,
  input wire logic [31:0]                   CMD_DATA,
  input wire logic                          INTEG_START,
  input wire logic                          READ_START,
  input wire logic                          INTEGRATING,
  input wire logic                          READING,
  input wire logic                          CMD_REJECT,
  input wire logic [3:0]                    MODE_RD,
  input wire logic [25:0]                   EXP_RD,
  input wire logic [7:0]                    RATE_RD
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  int rd_n;
  int in_n;
  // cycles spent reading and integrating
  always_ff @(posedge CORE_CLK) begin
    rd_n <= READING ? rd_n + 1 : 0;
    in_n <= INTEGRATING ? in_n + 1 : 0;
  end
  sequence integ_hold;
    INTEGRATING[*8];
  endsequence
  sequence integ_end;
    READ_START && READING;
  endsequence
  integ_on_a: assert property (INTEG_START |-> integ_hold)
    else $error("integration not held after start");
  integ_end_a: assert property ($fell(INTEGRATING) |-> integ_end)
    else $error("integration ended without readout start");
  integ_min_a: assert property ($fell(INTEGRATING) |-> in_n >= 1000)
    else $error("exposure shorter than minimum");
  rd_len_a: assert property ($fell(READING) |->
    rd_n inside {[READOUT_US*100-100 : READOUT_US*200+100]})
    else $error("readout length wrong");
  reject_keep_a: assert property (CMD_REJECT |-> $stable(MODE_RD)
    && $stable(RATE_RD) && $stable(EXP_RD))
    else $error("refused command changed a setting");
  exp_mode_a: assert property (CMD_STB
    && CMD_SEL == exposure_timing_pkg::CMD_EXPOSURE
    && MODE_RD inside {4'h4, 4'h9} |=> CMD_REJECT)
    else $error("exposure accepted in trigger-timed mode");
  rate_set_a: assert property (CMD_STB
    && CMD_SEL == exposure_timing_pkg::CMD_RATE
    && CMD_DATA inside {32'h50, 32'ha0} |=> RATE_RD == $past(CMD_DATA[7:0]))
    else $error("rate code not stored");
  mode_set_a: assert property (CMD_STB && !(CMD_DATA inside
    {32'h2, 32'h4, 32'h6, 32'h9, 32'ha})
    && CMD_SEL == exposure_timing_pkg::CMD_MODE |=> CMD_REJECT)
    else $error("illegal mode not refused");
  legal_set_a: assert property (RATE_RD inside {8'h50, 8'ha0}
    && MODE_RD inside {4'h2, 4'h4, 4'h6, 4'h9, 4'ha}
    && EXP_RD[25:4] >= 22'ha && EXP_RD[25:4] <= 22'h3d0900)
    else $error("setting outside its legal set");
endmodule
bind exposure_readout_timing_control exposure_timing_checker #(
  .READOUT_US(READOUT_US)
) i_chk (.*);

// [dv/frame_host_model.sv]
// host model driving the external frame trigger
// assumes go is a one-cycle pulse and high_cyc is held meanwhile
`timescale 1ns/100ps
module frame_host_model (
  input  wire logic        CORE_CLK,
  input  wire logic        go,
  input  wire logic [31:0] high_cyc,
  input  wire logic        reading,
  output logic             trig
);
  initial trig = 1'b0;
  always @(posedge CORE_CLK) begin
    if (go) begin
      for (int i = 0; i < 9000 && reading; i++) @(posedge CORE_CLK);
      trig <= 1'b1;
      repeat (high_cyc) @(posedge CORE_CLK);
      trig <= 1'b0;
    end
  end
endmodule

// [dv/testbench.sv]
// self-checking bench for the exposure timing controller
// assumes the host model, checker and constants header compile alongside
`timescale 1ns/100ps
`include "exposure_timing_consts.svh"
module testbench;
  localparam int RD_US = 20;
  logic                          core_clk = 1'b0;
  logic                          rst_n    = 1'b0;
  logic                          ovl_en   = 1'b1;
  logic                          cmd_stb  = 1'b0;
  exposure_timing_pkg::cmd_sel_t cmd_sel  = exposure_timing_pkg::CMD_MODE;
  logic [31:0]                   cmd_data = 32'h0;
  logic                          go       = 1'b0;
  logic [31:0]                   high_cyc = 32'h0;
  wire logic                     trig;
  wire logic                     integ_start;
  wire logic                     read_start;
  wire logic                     integrating;
  wire logic                     reading;
  wire logic                     warn_exp;
  wire logic                     warn_rate;
  wire logic                     cmd_reject;
  wire logic [3:0]               mode_rd;
  wire logic [25:0]              exp_rd;
  wire logic [23:0]              period_rd;
  wire logic [7:0]               rate_rd;
  int                            bad_count  = 0;
  int                            n_compared = 0;
  logic [31:0]                   d;
  logic [25:0]                   e;
  logic [23:0]                   per;
  logic                          we;
  logic                          wr;

  always #5 core_clk = ~core_clk;

  exposure_readout_timing_control #(
    .READOUT_US    (RD_US),
    .TRIG_DELAY_US (2)
  ) i_dut (
    .CORE_CLK          (core_clk),
    .RST_N             (rst_n),
    .EXT_FRAME_TRIGGER (trig),
    .OVERLAP_EN        (ovl_en),
    .CMD_STB           (cmd_stb),
    .CMD_SEL           (cmd_sel),
    .CMD_DATA          (cmd_data),
    .INTEG_START       (integ_start),
    .READ_START        (read_start),
    .INTEGRATING       (integrating),
    .READING           (reading),
    .WARN_EXP          (warn_exp),
    .WARN_RATE         (warn_rate),
    .CMD_REJECT        (cmd_reject),
    .MODE_RD           (mode_rd),
    .EXP_RD            (exp_rd),
    .PERIOD_RD         (period_rd),
    .RATE_RD           (rate_rd)
  );

  frame_host_model i_host (
    .CORE_CLK (core_clk),
    .go       (go),
    .high_cyc (high_cyc),
    .reading  (reading),
    .trig     (trig)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    rst_n   <= 1'b0;
    cmd_stb <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
  endtask

  task automatic chk_defaults;
    chk(mode_rd, `MODE_INT);
    chk(exp_rd, {`EXP_RESET_US, `EXP_FRAC_ZERO});
    chk(period_rd, `PERIOD_RESET_US);
    chk(rate_rd, `RATE_CODE_FAST);
    chk(integrating | reading, 32'h0);
  endtask

  task automatic cmd(input exposure_timing_pkg::cmd_sel_t s,
                     input logic [31:0] v);
    @(posedge core_clk);
    cmd_stb  <= 1'b1;
    cmd_sel  <= s;
    cmd_data <= v;
    ovl_en   <= 1'($urandom);
    @(posedge core_clk);
    cmd_stb <= 1'b0;
    #1;
  endtask

  // which: 0 integration start, 1 readout start, else both idle
  task automatic wait_on(input int which, input int limit, output int n);
    logic hit;
    hit = 1'b0;
    for (n = 0; n < limit && !hit; n++) begin
      @(posedge core_clk);
      #1;
      case (which)
        0: hit = integ_start;
        1: hit = read_start;
        default: hit = !integrating && !reading;
      endcase
    end
    if (!hit) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, which, limit);
    end
  endtask

  function automatic logic [25:0] exp_clip(input logic [31:0] v,
                                           input logic [21:0] lo);
    if (|v[31:26] || v[25:4] > `EXP_MAX_US) begin
      return {`EXP_MAX_US, `EXP_FRAC_ZERO};
    end else if (v[25:4] < lo) begin
      return {lo, `EXP_FRAC_ZERO};
    end
    return v[25:0];
  endfunction

  task automatic frame(input logic [3:0] m, input int h, input int lo,
                       input int hi);
    int n;
    cmd(exposure_timing_pkg::CMD_MODE, {28'h0, m});
    if (m == `MODE_FIXED || m == `MODE_FIXED_SEQ) begin
      cmd(exposure_timing_pkg::CMD_EXPOSURE, 32'h320);
      chk(exp_rd, 32'h320);
    end
    repeat (10) @(posedge core_clk);
    wait_on(2, 20000, n);
    @(posedge core_clk);
    go       <= 1'b1;
    high_cyc <= h;
    @(posedge core_clk);
    go <= 1'b0;
    wait_on(0, 20000, n);
    wait_on(1, 20000, n);
    chk_rng(n, lo, hi);
    wait_on(2, 10000, n);
    chk_rng(n, 1900, 2100);
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(66310));
    do_reset;
    chk_defaults;
    cmd(exposure_timing_pkg::CMD_RATE, 32'h50);
    chk(rate_rd, `RATE_CODE_SLOW);
    cmd(exposure_timing_pkg::CMD_RATE, 32'h51);
    chk(cmd_reject, 32'h1);
    chk(rate_rd, `RATE_CODE_SLOW);
    cmd(exposure_timing_pkg::CMD_RATE, 32'ha0);
    chk(rate_rd, `RATE_CODE_FAST);
    cmd(exposure_timing_pkg::CMD_MODE, 32'h3);
    chk(cmd_reject, 32'h1);
    per = `PERIOD_RESET_US;
    for (int i = 0; i < 30; i++) begin
      case ($urandom % 3)
        0: d = $urandom;
        1: d = $urandom % 32'h320;
        default: d = $urandom % 32'h4e200;
      endcase
      e  = exp_clip(d, `EXP_MIN_US);
      we = e[3:0] != `EXP_FRAC_ZERO && {2'b0, e[25:4]} + 24'(RD_US) > per;
      if (we) begin
        e[3:0] = `EXP_FRAC_ZERO;
      end
      wr = {2'b0, e[25:4]} > per;
      if (wr) begin
        per = {2'b0, e[25:4]};
      end
      cmd(exposure_timing_pkg::CMD_EXPOSURE, d);
      chk(exp_rd, e);
      chk(warn_exp, we);
      chk(warn_rate, wr);
      chk(period_rd, per);
    end
    we = {2'b0, e[25:4]} > 24'h64;
    if (we) begin
      e = {22'h64, `EXP_FRAC_ZERO};
    end
    cmd(exposure_timing_pkg::CMD_PERIOD, 32'h64);
    chk(period_rd, 32'h64);
    chk(exp_rd, e);
    chk(warn_exp, we);
    cmd(exposure_timing_pkg::CMD_EXPOSURE, 32'h280);
    chk(exp_rd, 32'h280);
    frame(`MODE_INT, 300, 3850, 4100);
    frame(`MODE_SMART, 6000, 5700, 5950);
    frame(`MODE_SMART_SEQ, 6000, 5700, 5950);
    frame(`MODE_FIXED, 300, 4850, 5100);
    frame(`MODE_FIXED_SEQ, 300, 4850, 5100);
    cmd(exposure_timing_pkg::CMD_MODE, 32'h4);
    cmd(exposure_timing_pkg::CMD_EXPOSURE, 32'h320);
    chk(cmd_reject, 32'h1);
    do_reset;
    chk_defaults;
    end_sim;
  end
endmodule
